// >>> isp_pkg.sv
// Shared constants and types for the input shift and power-up mode block.
package isp_pkg;
    localparam int ISP_W = 16;
    localparam logic signed [15:0] ISP_REF_MAX = 16'sh270F;
    localparam logic signed [15:0] ISP_REF_MIN = -16'sh07CF;
    localparam logic signed [15:0] ISP_REF1_DEF = 16'sh0000;
    localparam logic signed [15:0] ISP_REF2_DEF = 16'sh03E8;
    localparam logic signed [15:0] ISP_SHIFT_MAX = 16'sh270F;
    localparam logic signed [15:0] ISP_SHIFT_MIN = -16'sh07CF;
    localparam logic signed [15:0] ISP_SHIFT_DEF = 16'sh0000;
    localparam logic [1:0] ISP_DP_DEF = 2'h0;
    localparam logic [1:0] ISP_DP_ONE = 2'h1;
    localparam logic [1:0] ISP_PU_CONT = 2'h0;
    localparam logic [1:0] ISP_PU_STOP = 2'h1;
    localparam logic [1:0] ISP_PU_MAN = 2'h2;
    localparam logic [1:0] ISP_PU_DEF = 2'h0;

    typedef enum logic [2:0]
    {
        ISP_ST_RESET = 3'h1,
        ISP_ST_APPLY = 3'h2,
        ISP_ST_RUN = 3'h4
    } isp_state_t;
endpackage

// >>> isp_input_shift.sv
// Input shift correction and power-up operating mode selection.
module isp_input_shift
    import isp_pkg::*;
#(
    parameter int W = ISP_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_reset,
    // Configuration writes
    input wire logic cfg_we,
    input wire logic signed [W-1:0] cfg_ref1,
    input wire logic signed [W-1:0] cfg_ref2,
    input wire logic signed [W-1:0] cfg_shift1,
    input wire logic signed [W-1:0] cfg_shift2,
    input wire logic [1:0] cfg_dp,
    input wire logic analog_input,
    input wire logic pu_we,
    input wire logic [1:0] pu_sel_wdata,
    // Run and manual/auto control sources
    input wire logic cmd_run,
    input wire logic cmd_stop,
    input wire logic event_run,
    input wire logic event_stop,
    input wire logic cmd_manual,
    input wire logic cmd_auto,
    // Retained state from before power loss
    input wire logic prev_run,
    input wire logic prev_manual,
    input wire logic signed [W-1:0] prev_mv,
    input wire logic signed [W-1:0] mv_initial,
    input wire logic signed [W-1:0] mv_at_stop,
    // Measurement path
    input wire logic meas_valid,
    input wire logic signed [W-1:0] meas,
    // Outputs
    output logic pv_valid,
    output logic signed [W-1:0] process_value,
    output logic running,
    output logic manual,
    output logic signed [W-1:0] manipulated_output_value,
    output logic mv_load,
    output logic [1:0] pu_sel,
    output logic [1:0] pu_sel_active,
    output logic [1:0] pv_dp,
    output logic [1:0] shift_dp,
    output logic pu_reject
);
    // Product width: two differences of W+1 bits each.
    localparam int PW = 2 * W + 2;

    logic signed [W-1:0] ref1, ref2, shift1, shift2;
    logic signed [W-1:0] next_ref1, next_ref2, next_shift1, next_shift2;
    logic [1:0] next_pv_dp, next_shift_dp;
    logic [1:0] next_pu_sel, next_pu_sel_active;
    logic next_pu_reject;
    isp_state_t state, next_state;
    logic next_running, next_manual, next_mv_load;
    logic signed [W-1:0] next_mv;
    logic next_pv_valid;
    logic signed [W-1:0] next_pv;

    // Limits a written value to its legal range.
    function automatic logic signed [W-1:0] clampv(
        input logic signed [W-1:0] v,
        input logic signed [W-1:0] lo,
        input logic signed [W-1:0] hi);
        logic signed [W-1:0] r;
        r = v;
        if (v < lo)
            r = lo;
        if (v > hi)
            r = hi;
        return r;
    endfunction

    // Differences carry one extra bit, so that any two legal values
    // subtract without wrapping.
    function automatic logic signed [W:0] diffv(
        input logic signed [W-1:0] a,
        input logic signed [W-1:0] b);
        logic signed [W:0] d;
        d = {a[W-1], a} - {b[W-1], b};
        return d;
    endfunction

    // Configuration and selector storage.
    // Out-of-range configuration values are clamped, not refused, so a write lands; a selector code above ISP_PU_MAN is refused.
    always_comb
    begin
        next_ref1 = ref1;
        next_ref2 = ref2;
        next_shift1 = shift1;
        next_shift2 = shift2;
        next_pv_dp = pv_dp;
        next_shift_dp = shift_dp;
        next_pu_sel = pu_sel;
        next_pu_reject = 1'b0;
        if (cfg_we)
        begin
            next_ref1 = clampv(cfg_ref1, ISP_REF_MIN, ISP_REF_MAX);
            next_ref2 = clampv(cfg_ref2, ISP_REF_MIN, ISP_REF_MAX);
            next_shift1 = clampv(cfg_shift1, ISP_SHIFT_MIN, ISP_SHIFT_MAX);
            next_shift2 = clampv(cfg_shift2, ISP_SHIFT_MIN, ISP_SHIFT_MAX);
            next_pv_dp = cfg_dp;
            if (analog_input && cfg_dp == ISP_DP_DEF)
                next_shift_dp = ISP_DP_ONE;
            else
                next_shift_dp = cfg_dp;
        end

        // A refused write leaves the stored selector as it was.
        if (pu_we)
        begin
            if (running || pu_sel_wdata > ISP_PU_MAN)
                next_pu_reject = 1'b1;
            else
                next_pu_sel = pu_sel_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref1 <= ISP_REF1_DEF;
            ref2 <= ISP_REF2_DEF;
            shift1 <= ISP_SHIFT_DEF;
            shift2 <= ISP_SHIFT_DEF;
            pv_dp <= ISP_DP_DEF;
            shift_dp <= ISP_DP_ONE;
            pu_sel <= ISP_PU_DEF;
            pu_reject <= 1'b0;
        end
        else
        begin
            ref1 <= next_ref1;
            ref2 <= next_ref2;
            shift1 <= next_shift1;
            shift2 <= next_shift2;
            pv_dp <= next_pv_dp;
            shift_dp <= next_shift_dp;
            pu_sel <= next_pu_sel;
            pu_reject <= next_pu_reject;
        end
    end

    // Correction line; a narrow divider would be cheaper but one cycle of
    // latency is all the measurement path tolerates here.
    logic signed [W:0] dref, dshift, dx;
    logic signed [PW-1:0] prod, quot;
    always_comb
    begin
        dref = diffv(ref2, ref1);
        dshift = diffv(shift2, shift1);
        dx = diffv(meas, ref1);
        prod = PW'(dshift) * PW'(dx);
        if (dshift == '0 || dref == '0)
            quot = '0;
        else
            // Division truncates toward zero, so fractions are dropped.
            // two pairs
            quot = prod / PW'(dref);
        // The sum is cut to W bits: a steep line extrapolated far from the
        // references wraps, so keep the two references well apart.
        next_pv = W'(PW'(meas) + PW'(shift1) + quot);
        next_pv_valid = meas_valid;
    end

    // Registered so that the corrected value leaves from a flip-flop.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            process_value <= '0;
            pv_valid <= 1'b0;
        end
        else
        begin
            process_value <= next_pv;
            pv_valid <= next_pv_valid;
        end
    end

    // Power-up sequencing, entered on power-on and on software reset.
    always_comb
    begin
        next_state = state;
        next_running = running;
        next_manual = manual;
        next_mv = manipulated_output_value;
        next_mv_load = 1'b0;
        next_pu_sel_active = pu_sel_active;

        unique case (state)
            ISP_ST_RESET:
            begin
                // The selector in effect is copied only here, so a write
                // made while stopped waits for the next reset.
                // latch at reset
                next_pu_sel_active = pu_sel;
                next_state = ISP_ST_APPLY;
            end
            ISP_ST_APPLY:
            begin
                // The retained inputs are sampled in this cycle only.
                // apply selection
                next_running = prev_run;
                next_manual = prev_manual;
                if (pu_sel_active == ISP_PU_STOP)
                    next_running = 1'b0;
                if (pu_sel_active == ISP_PU_MAN)
                    next_manual = 1'b1;
                if (prev_manual)
                    next_mv = prev_mv;
                else if (pu_sel_active == ISP_PU_CONT && prev_run)
                    next_mv = mv_initial;
                else
                    next_mv = mv_at_stop;
                // The pulse marks the cycle the restored value appears.
                next_mv_load = 1'b1;
                next_state = ISP_ST_RUN;
            end
            ISP_ST_RUN:
            begin
                // Stop wins over run, so a stuck request cannot restart.
                // two start sources
                if (cmd_stop || event_stop)
                    next_running = 1'b0;
                else if (cmd_run || event_run)
                    next_running = 1'b1;
                if (cmd_manual)
                    next_manual = 1'b1;
                else if (cmd_auto)
                    next_manual = 1'b0;
            end
            // An illegal code restarts the power-up sequence.
            default:
                next_state = ISP_ST_RESET;
        endcase

        // A software reset overrides every state.
        if (soft_reset)
            next_state = ISP_ST_RESET;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ISP_ST_RESET;
            running <= 1'b0;
            manual <= 1'b0;
            manipulated_output_value <= '0;
            mv_load <= 1'b0;
            pu_sel_active <= ISP_PU_DEF;
        end
        else
        begin
            state <= next_state;
            running <= next_running;
            manual <= next_manual;
            manipulated_output_value <= next_mv;
            mv_load <= next_mv_load;
            pu_sel_active <= next_pu_sel_active;
        end
    end
endmodule

// >>> isp_chk.sv
// Port checker for the input shift and power-up mode block.
module isp_chk
    import isp_pkg::*;
(
    // Clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_reset,
    // Inputs
    input wire logic cfg_we,
    input wire logic [1:0] cfg_dp,
    input wire logic analog_input,
    input wire logic pu_we,
    input wire logic [1:0] pu_sel_wdata,
    input wire logic cmd_stop,
    input wire logic event_stop,
    // Outputs
    input wire logic running,
    input wire logic manual,
    input wire logic mv_load,
    input wire logic [1:0] pu_sel,
    input wire logic [1:0] pu_sel_active,
    input wire logic [1:0] pv_dp,
    input wire logic [1:0] shift_dp,
    input wire logic pu_reject
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_wr_ok;
        pu_we && !running && pu_sel_wdata != 2'h3;
    endsequence
    // The latch happens within two edges of a soft reset, so four are quiet.
    sequence s_quiet;
        !soft_reset [*4];
    endsequence
    // The end of a software reset pulse of any length.
    sequence s_sr_end;
        soft_reset ##1 !soft_reset;
    endsequence
    AST_DP: assert property (cfg_we |=> pv_dp == $past(cfg_dp))
        else $error("pv_dp wrong");
    AST_SDP: assert property (cfg_we && analog_input && cfg_dp == 2'h0
        |=> shift_dp == 2'h1) else $error("shift_dp wrong");
    AST_OK: assert property (s_wr_ok |=> pu_sel == $past(pu_sel_wdata))
        else $error("selector write lost");
    AST_REJ: assert property (pu_we && running |=> pu_reject
        && $stable(pu_sel)) else $error("selector write not refused");
    AST_KEEP: assert property (s_quiet |=> $stable(pu_sel_active))
        else $error("active selector changed");
    // stop takes effect
    // Requests are ignored in the two cycles of the power-up sequence.
    AST_STOP: assert property ((cmd_stop || event_stop) && running
        && !$past(soft_reset) && !$past(soft_reset, 2)
        && !$past(rst) && !$past(rst, 2)
        |=> !running) else $error("stop ignored");
    AST_SRST: assert property (s_sr_end |-> ##[1:2] mv_load)
        else $error("restore missing after soft reset");
    AST_FSTOP: assert property (mv_load && pu_sel_active == ISP_PU_STOP
        |-> !running) else $error("stop not forced");
    AST_FMAN: assert property (mv_load && pu_sel_active == ISP_PU_MAN
        |-> manual) else $error("manual not forced");
endmodule

bind isp_input_shift isp_chk u_isp_chk (
    .clk, .rst, .soft_reset, .cfg_we, .cfg_dp, .analog_input, .pu_we,
    .pu_sel_wdata, .cmd_stop, .event_stop, .running, .manual, .mv_load,
    .pu_sel, .pu_sel_active, .pv_dp, .shift_dp, .pu_reject
);

// >>> tb_isp_input_shift.sv
// Self-checking bench for the input shift and power-up mode block.
module tb_isp_input_shift
    import isp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, sr = 1'b0, we = 1'b0, pwe = 1'b0;
    logic an = 1'b0, mva = 1'b0, pr = 1'b1, pm = 1'b0;
    logic [3:0] rc = 4'h0;
    logic [1:0] mc = 2'h0, dp = 2'h0, ws = 2'h0, act = ISP_PU_DEF;
    logic signed [15:0] r1 = 16'sh0000, r2 = 16'sh03E8, s1 = 16'sh0000;
    logic signed [15:0] s2 = 16'sh0000, m = 16'sh0000, pmv = 16'sh0111;
    logic signed [15:0] mvi = 16'sh0222, mvs = 16'sh0333, pv, mv;
    logic pvv, run, man, mvl, rej;
    logic [1:0] sel, sela, pdp, sdp;
    int err_count = 0;
    int comparisons = 0;
    isp_input_shift u_isp_input_shift (
        .clk(clk), .rst(rst), .soft_reset(sr), .cfg_we(we),
        .cfg_ref1(r1), .cfg_ref2(r2), .cfg_shift1(s1), .cfg_shift2(s2),
        .cfg_dp(dp), .analog_input(an), .pu_we(pwe), .pu_sel_wdata(ws),
        .cmd_run(rc[3]), .cmd_stop(rc[2]), .event_run(rc[1]),
        .event_stop(rc[0]), .cmd_manual(mc[1]), .cmd_auto(mc[0]),
        .prev_run(pr), .prev_manual(pm), .prev_mv(pmv), .mv_initial(mvi),
        .mv_at_stop(mvs), .meas_valid(mva), .meas(m), .pv_valid(pvv),
        .process_value(pv), .running(run), .manual(man),
        .manipulated_output_value(mv), .mv_load(mvl), .pu_sel(sel),
        .pu_sel_active(sela), .pv_dp(pdp), .shift_dp(sdp), .pu_reject(rej)
    );
    always #5 clk = ~clk;
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chs(input string n, input logic [1:0] e, g);
        chk(n, {14'h0000, e}, {14'h0000, g});
    endtask
    // A restore that never comes must not hang the run.
    task automatic wl();
        int i;
        for (i = 0; i < 9 && mvl !== 1'b1; i++)
            @(negedge clk);
        if (i == 9)
        begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic cfg(input logic signed [15:0] a, b, c, d,
        input logic [1:0] p, input logic q);
        {r1, r2, s1, s2, dp, an} = {a, b, c, d, p, q};
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic pvc(input logic signed [15:0] x, e);
        m = x;
        mva = 1'b1;
        @(negedge clk);
        mva = 1'b0;
        chs("pv_valid", 2'h1, {1'b0, pvv});
        chk("process_value", e, pv);
        @(negedge clk);
        chs("pv_valid", 2'h0, {1'b0, pvv});
    endtask
    task automatic pl(input logic [3:0] r, input logic [1:0] k,
        input logic er, em);
        {rc, mc} = {r, k};
        @(negedge clk);
        {rc, mc} = 6'h00;
        chs("running", {1'b0, er}, {1'b0, run});
        chs("manual", {1'b0, em}, {1'b0, man});
        @(negedge clk);
    endtask
    task automatic wr(input logic [1:0] v);
        ws = v;
        pwe = 1'b1;
        @(negedge clk);
        pwe = 1'b0;
    endtask
    task automatic t_shift();
        pvc(16'sh01F4, 16'sh01F4);
        cfg(16'sh0000, 16'sh03E8, 16'sh000C, 16'sh000C, 2'h1, 1'b0);
        chs("pv_dp", 2'h1, pdp);
        pvc(16'sh07D0, 16'sh07DC);
        cfg(16'sh0028, 16'sh01F4, -16'sh000F, 16'sh0032, 2'h0, 1'b1);
        chs("shift_dp", 2'h1, sdp);
        pvc(16'sh0028, 16'sh0019);
        pvc(16'sh010E, 16'sh011F);
        pvc(16'sh03C0, 16'sh0433);
        pvc(16'sh0000, -16'sh0014);
        cfg(16'sh0000, 16'sh03E8, -16'sh1000, -16'sh1000, 2'h0, 1'b0);
        pvc(16'sh0800, 16'sh0031);
        cfg(16'sh0000, 16'sh7FFF, 16'sh0000, 16'sh270F, 2'h0, 1'b0);
        pvc(16'sh270F, 16'sh4E1E);
        $display("done shift");
    endtask
    task automatic t_run();
        pl(4'h1, 2'h0, 1'b0, 1'b0);
        pl(4'h2, 2'h0, 1'b1, 1'b0);
        pl(4'h6, 2'h2, 1'b0, 1'b1);
        pl(4'h8, 2'h3, 1'b1, 1'b1);
        pl(4'h0, 2'h1, 1'b1, 1'b0);
        $display("done run");
    endtask
    task automatic t_pu(input logic [1:0] s, k);
        logic er;
        pl(4'h4, 2'h1, 1'b0, 1'b0);
        wr(s);
        chs("pu_sel", s, sel);
        chs("pu_sel_active", act, sela);
        {pr, pm} = k;
        sr = 1'b1;
        @(negedge clk);
        sr = 1'b0;
        wl();
        act = s;
        er = (s == ISP_PU_STOP) ? 1'b0 : pr;
        chs("pu_sel_active", s, sela);
        chs("running", {1'b0, er}, {1'b0, run});
        chs("manual", {1'b0, pm | (s == ISP_PU_MAN)}, {1'b0, man});
        chk("mv", pm ? pmv : (!s && pr) ? mvi : mvs, mv);
        if (er)
        begin
            wr((s == ISP_PU_MAN) ? ISP_PU_CONT : ISP_PU_MAN);
            chs("pu_reject", 2'h1, {1'b0, rej});
            chs("pu_sel", s, sel);
        end
        $display("done power-up %0d %0d", s, k);
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        chs("shift_dp", 2'h1, sdp);
        rst = 1'b0;
        wl();
        chk("mv", mvi, mv);
        t_shift();
        t_run();
        for (int s = 0; s < 3; s++)
            for (int k = 0; k < 4; k++)
                t_pu(2'(s), 2'(k));
        pl(4'h4, 2'h0, 1'b0, 1'b1);
        wr(2'h3);
        chs("pu_reject", 2'h1, {1'b0, rej});
        rst = 1'b1;
        @(negedge clk);
        chs("pu_sel", ISP_PU_DEF, sel);
        rst = 1'b0;
        wl();
        chk("mv", pmv, mv);
        end_of_test();
    end
endmodule
